// ---- hw/iacs_pkg.sv ----
package iacs_pkg;
  // AXI4-Lite register byte addresses
  localparam logic [7:0] ADDR_CFG0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_STAT   = 8'h0c;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_MOD    = 8'h14;

  // acq_config_zero fields
  localparam int OSR_LSB  = 2;
  localparam int OSR_MSB  = 4;
  localparam int NELC_LSB = 5;
  localparam int NELC_MSB = 6;
  localparam int FIN_LSB  = 0;
  localparam int FIN_MSB  = 1;
  localparam logic [7:0] CFG0_RESET = 8'h00;

  // Control register bits (self clearing)
  localparam int CTRL_START = 0;
  localparam int CTRL_DEF   = 1;

  // Status bits
  localparam int STAT_DONE = 0;
  localparam int STAT_SAT  = 1;
  localparam int STAT_W    = 2;

  localparam int OSR_BASE_LOG = 3;

  // RC clock is sys_clk; approximately 8 kHz tick for code 11
  localparam int SYS_CLK_HZ  = 20_000_000;
  localparam int SLOW_FS_HZ  = 8_000;
  localparam int SLOW_DIV    = SYS_CLK_HZ / SLOW_FS_HZ;
  localparam int DIV_W       = 12;
  localparam logic [DIV_W-1:0] DIV_4    = 12'h004;
  localparam logic [DIV_W-1:0] DIV_8    = 12'h008;
  localparam logic [DIV_W-1:0] DIV_32   = 12'h020;
  localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(SLOW_DIV);

  localparam int ACC_W = 24;
  localparam logic signed [15:0] FS_POS = 16'sh7fff;
  localparam logic signed [15:0] FS_NEG = -16'sh8000;

  typedef enum logic [1:0] {
    IACS_IDLE  = 2'b00,
    IACS_ELEM  = 2'b01,
    IACS_QUANT = 2'b11,
    IACS_LOAD  = 2'b10
  } iacs_state_e;
endpackage

// ---- hw/iacs_tick_div.sv ----
`timescale 1ns/1ps
module iacs_tick_div (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic [1:0] rate_sel,
  output logic            tick
);
  typedef struct packed {
    logic [iacs_pkg::DIV_W-1:0] cnt;
    logic                       tick;
  } iacs_div_s;

  iacs_div_s s_q;
  iacs_div_s s_d;
  logic [iacs_pkg::DIV_W-1:0] period;

  always_comb
  begin
    unique case (rate_sel)
      2'b00: period = iacs_pkg::DIV_4;
      2'b01: period = iacs_pkg::DIV_8;
      2'b10: period = iacs_pkg::DIV_32;
      2'b11: period = iacs_pkg::DIV_SLOW;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run)
      s_d.cnt = '0;
    else if (s_q.cnt == period - 1'b1)
    begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end
    else
      s_d.cnt = s_q.cnt + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;
endmodule

// ---- hw/iacs_modulator_if.sv ----
`timescale 1ns/1ps
// Counts modulator ones over one elementary conversion as an up/down code
module iacs_modulator_if (
  input  wire logic                             sys_clk,
  input  wire logic                             srst,
  input  wire logic                             clear,
  input  wire logic                             sample,
  input  wire logic                             bit_in,
  output logic signed [iacs_pkg::ACC_W-1:0]     count
);
  typedef struct packed {
    logic       meta;
    logic       sync;
    logic signed [iacs_pkg::ACC_W-1:0] cnt;
  } iacs_mod_s;

  iacs_mod_s s_q;
  iacs_mod_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.meta = bit_in;
    s_d.sync = s_q.meta;
    if (clear)
      s_d.cnt = '0;
    else if (sample)
      s_d.cnt = s_q.sync ? s_q.cnt + 1'b1 : s_q.cnt - 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign count = s_q.cnt;
endmodule

// ---- hw/iacs_top.sv ----
// Notes on behaviour
// - Setting start or default-trigger bit while idle begins a new conversion; during a conversion it is ignored.
// - Conversion is N elementary conversions back to back, then one quantization step.
// - Each elementary conversion lasts OSR plus one sampling periods.
// - Result is the mean of the elementary results.
// - Offset polarity alternates between successive elementary conversions.
// - Rate field selects RC divided by 4, 8, 32, or about 8 kHz.
// - Config zero bits 4..2 oversampling_ratio_select to two to the three plus field.
// - Config zero bits 6..5 set elementary count to two to the field.
// - Result LSB weighs 2^15 / OSR, so at most log2 OSR plus one bits; the truncated mean adds none for N.
// - Total time is N times OSR plus one, plus one sampling period.
// - Result is a 16-bit two's complement word, high and low byte.
// - Out of range results saturate to 0x7fff or 0x8000.
`timescale 1ns/1ps
module iacs_top (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mod_bit,
  output logic             mod_reset,
  output logic             offset_invert,
  output logic             conv_busy,
  output logic             irq
);
  typedef struct packed {
    iacs_pkg::iacs_state_e     st;
    logic [7:0]                cfg0;
    logic [3:0]                nelc;
    logic [10:0]               osr;
    logic [10:0]               per_cnt;
    logic [3:0]                elem_cnt;
    logic                      polarity;
    logic signed [iacs_pkg::ACC_W+3:0] sum;
    logic [15:0]               result;
    logic [iacs_pkg::STAT_W-1:0] stat;
    logic [iacs_pkg::STAT_W-1:0] mask;
    logic                      aw_hold;
    logic [7:0]                aw_addr;
    logic                      w_hold;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      bvalid;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic [1:0]                bresp;
    logic                      mb_meta;
    logic                      mb_sync;
  } iacs_top_s;

  iacs_top_s s_q;
  iacs_top_s s_d;

  logic tick;
  logic signed [iacs_pkg::ACC_W-1:0] mod_count;
  logic mod_clear;
  logic signed [iacs_pkg::ACC_W+3:0] mean;
  logic signed [iacs_pkg::ACC_W+3:0] scaled;
  logic [15:0] sat_code;
  logic        sat_flag;
  logic        trig;
  logic        wr_go;
  logic        rd_go;

  function automatic logic [3:0] log2_osr(input logic [2:0] sel);
    log2_osr = 4'(sel) + 4'(iacs_pkg::OSR_BASE_LOG);
  endfunction

  function automatic logic in_map(input logic [7:0] a);
    in_map = (a == iacs_pkg::ADDR_CFG0) || (a == iacs_pkg::ADDR_CTRL)
          || (a == iacs_pkg::ADDR_RESULT) || (a == iacs_pkg::ADDR_STAT)
          || (a == iacs_pkg::ADDR_MASK) || (a == iacs_pkg::ADDR_MOD);
  endfunction

  iacs_tick_div u_div (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .run      (s_q.st != iacs_pkg::IACS_IDLE),
    .rate_sel (s_q.cfg0[iacs_pkg::FIN_MSB:iacs_pkg::FIN_LSB]),
    .tick     (tick)
  );

  iacs_modulator_if u_mod (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clear   (mod_clear),
    .sample  (tick && s_q.st == iacs_pkg::IACS_ELEM),
    .bit_in  (s_q.mb_sync ^ s_q.polarity),
    .count   (mod_count)
  );

  assign wr_go = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
  assign rd_go = s_axi_arvalid && !s_q.rvalid;
  assign trig  = wr_go && s_q.aw_addr == iacs_pkg::ADDR_CTRL && s_q.w_strb[0]
              && (s_q.w_data[iacs_pkg::CTRL_START] || s_q.w_data[iacs_pkg::CTRL_DEF]);
  assign mod_clear = s_q.st == iacs_pkg::IACS_IDLE
                  || (tick && s_q.st == iacs_pkg::IACS_ELEM && s_q.per_cnt == s_q.osr);

  // Mean by arithmetic shift, since N is a power of two
  assign mean = s_q.sum >>> $clog2(1) >>> s_q.elem_cnt;
  // Scale to 16-bit full scale: code = mean * 2^15 / OSR; OSR never exceeds 2^10,
  // so the shift is always left and the 16-bit word caps the resolution
  assign scaled = mean <<< (4'd15 - log2_osr(s_q.cfg0[iacs_pkg::OSR_MSB:iacs_pkg::OSR_LSB]));

  always_comb
  begin
    sat_flag = 1'b0;
    sat_code = scaled[15:0];
    if (scaled > (iacs_the_max()))
    begin
      sat_code = iacs_pkg::FS_POS;
      sat_flag = 1'b1;
    end
    else if (scaled < (iacs_the_min()))
    begin
      sat_code = iacs_pkg::FS_NEG;
      sat_flag = 1'b1;
    end
  end

  function automatic logic signed [iacs_pkg::ACC_W+3:0] iacs_the_max();
    iacs_the_max = (iacs_pkg::ACC_W+4)'(iacs_pkg::FS_POS);
  endfunction

  function automatic logic signed [iacs_pkg::ACC_W+3:0] iacs_the_min();
    iacs_the_min = (iacs_pkg::ACC_W+4)'(iacs_pkg::FS_NEG);
  endfunction

  always_comb
  begin
    s_d = s_q;
    // Pin is asynchronous: two flops before the polarity logic reads it
    s_d.mb_meta = mod_bit;
    s_d.mb_sync = s_q.mb_meta;
    // Sequencer
    unique case (s_q.st)
      iacs_pkg::IACS_IDLE:
      begin
        if (trig)
        begin
          s_d.st       = iacs_pkg::IACS_ELEM;
          s_d.osr      = 11'(1) << log2_osr(s_q.cfg0[iacs_pkg::OSR_MSB:iacs_pkg::OSR_LSB]);
          s_d.nelc     = 4'(1) << s_q.cfg0[iacs_pkg::NELC_MSB:iacs_pkg::NELC_LSB];
          s_d.per_cnt  = '0;
          s_d.elem_cnt = '0;
          s_d.polarity = 1'b0;
          s_d.sum      = '0;
        end
      end
      iacs_pkg::IACS_ELEM:
      begin
        if (tick)
        begin
          if (s_q.per_cnt == s_q.osr)
          begin
            s_d.per_cnt  = '0;
            // Undo the offset inversion so both polarities add the same sign of signal
            s_d.sum      = s_q.polarity ? s_q.sum - mod_count : s_q.sum + mod_count;
            s_d.polarity = ~s_q.polarity;
            s_d.elem_cnt = s_q.elem_cnt + 1'b1;
            if (s_q.elem_cnt + 1'b1 == s_q.nelc)
              s_d.st = iacs_pkg::IACS_QUANT;
          end
          else
            s_d.per_cnt = s_q.per_cnt + 1'b1;
        end
      end
      iacs_pkg::IACS_QUANT:
      begin
        if (tick)
        begin
          s_d.st       = iacs_pkg::IACS_LOAD;
          s_d.elem_cnt = 4'($clog2(1)) + 4'(s_q.cfg0[iacs_pkg::NELC_MSB:iacs_pkg::NELC_LSB]);
        end
      end
      iacs_pkg::IACS_LOAD:
      begin
        s_d.result = sat_code;
        s_d.st     = iacs_pkg::IACS_IDLE;
      end
    endcase

    // AXI4-Lite write side: address and data taken in either order
    if (s_axi_awvalid && !s_q.aw_hold)
    begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_hold)
    begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (wr_go)
    begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = in_map(s_q.aw_addr) ? 2'b00 : 2'b10;
      if (s_q.aw_addr == iacs_pkg::ADDR_CFG0 && s_q.w_strb[0])
        s_d.cfg0 = s_q.w_data[7:0];
      if (s_q.aw_addr == iacs_pkg::ADDR_MASK && s_q.w_strb[0])
        s_d.mask = s_q.w_data[iacs_pkg::STAT_W-1:0];
      if (s_q.aw_addr == iacs_pkg::ADDR_STAT && s_q.w_strb[0])
        s_d.stat = s_q.stat & ~s_q.w_data[iacs_pkg::STAT_W-1:0];
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // Hardware set wins over a same-cycle clear
    if (s_q.st == iacs_pkg::IACS_LOAD)
    begin
      s_d.stat[iacs_pkg::STAT_DONE] = 1'b1;
      if (sat_flag)
        s_d.stat[iacs_pkg::STAT_SAT] = 1'b1;
    end

    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = in_map(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        iacs_pkg::ADDR_CFG0:   s_d.rdata = {24'h000000, s_q.cfg0};
        iacs_pkg::ADDR_RESULT: s_d.rdata = {16'h0000, s_q.result};
        iacs_pkg::ADDR_STAT:   s_d.rdata = 32'(s_q.stat);
        iacs_pkg::ADDR_MASK:   s_d.rdata = 32'(s_q.mask);
        iacs_pkg::ADDR_MOD:    s_d.rdata = {30'h00000000, s_q.polarity,
                                            s_q.st != iacs_pkg::IACS_IDLE};
        default:               s_d.rdata = 32'h00000000;
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_q      <= '0;
      s_q.cfg0 <= iacs_pkg::CFG0_RESET;
    end
    else
      s_q <= s_d;
  end

  assign s_axi_awready = !s_q.aw_hold;
  assign s_axi_wready  = !s_q.w_hold;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign mod_reset     = mod_clear;
  assign offset_invert = s_q.polarity;
  assign conv_busy     = s_q.st != iacs_pkg::IACS_IDLE;
  assign irq           = |(s_q.stat & s_q.mask);
endmodule

// ---- dv/iacs_top_asserts.sv ----
`timescale 1ns/1ps
module iacs_top_asserts (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        mod_reset,
  input wire logic        offset_invert,
  input wire logic        conv_busy,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  AST_IDLE_MODRST: assert property (!conv_busy |-> mod_reset)
    else $error("modulator not held in reset while idle");
  AST_INV_FIRST: assert property ($rose(conv_busy) |-> !offset_invert)
    else $error("first elementary conversion not at plain polarity");
  // Polarity may only rise right after an elementary conversion ends
  AST_INV_TOGGLE: assert property ($rose(offset_invert) |-> $past(mod_reset))
    else $error("polarity flipped inside an elementary conversion");
  AST_RD_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RD_ERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h18
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_B_BOUND: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");

  cover property ($fell(conv_busy));
  cover property ($rose(irq));
  cover property ($rose(offset_invert));
endmodule

bind iacs_top iacs_top_asserts u_chk (
  .sys_clk(sys_clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mod_reset(mod_reset),
  .offset_invert(offset_invert), .conv_busy(conv_busy), .irq(irq)
);

// ---- dv/iacs_top_test.sv ----
`timescale 1ns/1ps
module iacs_top_test;
  typedef struct {
    logic [7:0]  cfg;
    int          trig;
    logic        mb;
    int          ticks;
    int          div;
    logic [15:0] res;
    logic [31:0] sts;
  } iacs_row_s;

  logic        sys_clk, srst, mod_bit;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, mod_reset, offset_invert, conv_busy, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  int          bad_count, n_checks, m, e;
  // Every rate code at least once; counts kept short so the run stays brief
  // Negative full scale is representable, so it does not flag saturation
  iacs_row_s   rows [5] = '{'{8'h00, 0, 1'b1, 10, 4, 16'h7fff, 32'h3},
                            '{8'h20, 1, 1'b0, 19, 4, 16'h8000, 32'h1},
                            '{8'h45, 0, 1'b1, 69, 8, 16'h7fff, 32'h3},
                            '{8'h62, 1, 1'b0, 73, 32, 16'h8000, 32'h1},
                            '{8'h03, 0, 1'b1, 10, 2500, 16'h7fff, 32'h3}};

  iacs_top dut (
    .sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .mod_bit(mod_bit), .mod_reset(mod_reset), .offset_invert(offset_invert),
    .conv_busy(conv_busy), .irq(irq)
  );

  task automatic tally_and_finish;
    begin
      if (bad_count == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    begin
      n_checks++;
      if (g !== x)
      begin
        bad_count++;
        $display("Error %s expected %h seen %h", n, x, g);
      end
    end
  endtask

  // Each task starts one edge late so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    begin
      t = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge sys_clk);
        t++;
        if (s_axi_awready === 1'b1)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1)
          s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && t < 50);
      s_axi_bready <= 1'b0;
      chk("write answer", 32'h1, 32'(t < 50));
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    begin
      t = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge sys_clk);
        t++;
        if (s_axi_arready === 1'b1)
          s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && t < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  task automatic conv(input int trig, output int n);
    int t;
    begin
      t = 0;
      n = 0;
      wr(iacs_pkg::ADDR_CTRL, 32'h1 << trig);
      while (conv_busy !== 1'b1 && t < 20)
      begin
        @(posedge sys_clk);
        t++;
      end
      while (conv_busy === 1'b1 && n < 40000)
      begin
        @(posedge sys_clk);
        n++;
      end
    end
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial
  begin
    #4000000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, mod_bit} = '0;
    srst = 1'b1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    wr(iacs_pkg::ADDR_MASK, 32'h1);
    foreach (rows[i])
    begin
      mod_bit <= rows[i].mb;
      wr(iacs_pkg::ADDR_CFG0, {24'h0, rows[i].cfg});
      conv(rows[i].trig, m);
      e = rows[i].ticks * rows[i].div;
      // Divider restarts at zero on start, so no phase is saved; the lower bound still allows one sampling period
      chk("duration", 32'h1, 32'(m >= e - rows[i].div && m <= e + 16));
      chk("irq raised", 32'h1, 32'(irq));
      rd(iacs_pkg::ADDR_RESULT, rdv, rr);
      chk("result", {16'h0, rows[i].res}, rdv);
      rd(iacs_pkg::ADDR_STAT, rdv, rr);
      chk("status", rows[i].sts, rdv);
      wr(iacs_pkg::ADDR_STAT, 32'h3);
      rd(iacs_pkg::ADDR_STAT, rdv, rr);
      chk("status cleared", 32'h0, rdv);
      chk("irq cleared", 32'h0, 32'(irq));
    end
    rd(iacs_pkg::ADDR_CTRL, rdv, rr);
    chk("ctrl reads zero", 32'h0, rdv);
    rd(8'h40, rdv, rr);
    chk("unmapped resp", 32'h2, 32'(rr));
    chk("unmapped data", 32'h0, rdv);
    wr(iacs_pkg::ADDR_MASK, 32'h0);
    wr(iacs_pkg::ADDR_CFG0, 32'h7c);
    conv(1, m);
    chk("irq masked", 32'h0, 32'(irq));
    rd(iacs_pkg::ADDR_RESULT, rdv, rr);
    chk("result max osr", 32'h7fff, rdv);
    wr(iacs_pkg::ADDR_MASK, 32'h1);
    chk("irq unmasked", 32'h1, 32'(irq));
    wr(iacs_pkg::ADDR_STAT, 32'h1);
    chk("irq after clear", 32'h0, 32'(irq));
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rd(iacs_pkg::ADDR_CFG0, rdv, rr);
    chk("cfg after reset", {24'h0, iacs_pkg::CFG0_RESET}, rdv);
    rd(iacs_pkg::ADDR_STAT, rdv, rr);
    chk("status after reset", 32'h0, rdv);
    tally_and_finish();
  end
endmodule
